// ===== core/cpu_instr_subset_exec.sv
// Executor for the skip, increment, OR and absolute branch subset of the core.
`timescale 1ns/1ns
module cpu_instr_subset_exec
  import exec_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  input  wire instr_type              instr,
  output logic                        instr_ready,
  input  wire logic [LATCH_W-1:0]     upper_address_latch,
  output logic [DATA_W-1:0]           acc,
  output logic                        zero_flag,
  output logic [PC_W-1:0]             program_counter,
  output logic                        no_operation_cycle,
  output logic                        retired,
  input  wire logic [FILE_ADDR_W-1:0] peek_addr,
  output logic [DATA_W-1:0]           peek_data
);

  // ****************************************************************
  // State.
  // ****************************************************************
  // The skip marker rides with the phase so the flush cycle knows whether to step the counter.
  typedef struct packed {
    phase_type      phase;
    logic           skip_pending;
    core_state_type core;
  } exec_state_type;

  exec_state_type st_q;
  exec_state_type st_d;

  // Data file port signals.
  logic [DATA_W-1:0] file_rd_data;
  logic              file_wr_en;
  logic [DATA_W-1:0] file_wr_data;

  // Datapath results, all formed from the current operand.
  logic [DATA_W-1:0] dec_result;
  logic [DATA_W-1:0] inc_result;
  logic [DATA_W-1:0] or_lit_result;
  logic [DATA_W-1:0] or_file_result;
  logic [PC_W-1:0]   branch_target;
  logic              take;

  // ****************************************************************
  // Data file.
  // ****************************************************************
  file_store #(
    .ADDR_W (FILE_ADDR_W),
    .WORD_W (DATA_W)
  ) u_file_store (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .rd_addr   (instr.file_addr),
    .rd_data   (file_rd_data),
    .wr_en     (file_wr_en),
    .wr_addr   (instr.file_addr),
    .wr_data   (file_wr_data),
    .peek_addr (peek_addr),
    .peek_data (peek_data)
  );

  // ****************************************************************
  // Arithmetic and branch target.
  // ****************************************************************

  // Eight-bit wrap is intended: 8'h00 minus one gives 8'hFF, 8'hFF plus one gives zero.
  assign dec_result     = file_rd_data - DATA_ONE;
  assign inc_result     = file_rd_data + DATA_ONE;
  assign or_lit_result  = st_q.core.acc | instr.literal[DATA_W-1:0];
  assign or_file_result = st_q.core.acc | file_rd_data;

  // Upper program counter bits come from the latch, lower from the operand.
  assign branch_target = {upper_address_latch[LATCH_HI:LATCH_LO],
                          instr.literal[BRANCH_W-1:0]};

  // A new instruction is only taken while no flush cycle is pending.
  assign instr_ready = (st_q.phase == ST_EXECUTE);
  assign take        = instr.valid && instr_ready;

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************

  // One instruction per cycle; skips and branches add one flush cycle in which
  // the pipeline slot runs as a no-operation and nothing is accepted.
  always_comb begin
    st_d                   = st_q;
    st_d.skip_pending      = 1'b0;
    st_d.core.no_operation = 1'b0;
    st_d.core.retired      = 1'b0;
    file_wr_en             = 1'b0;
    file_wr_data           = DATA_ZERO;
    unique case (st_q.phase)
      ST_EXECUTE: begin
        if (take) begin
          st_d.core.retired         = 1'b1;
          st_d.core.program_counter = st_q.core.program_counter + PC_STEP;
          unique case (instr.op)
            DECREMENT_SKIP_ON_NULL: begin
              // Flags untouched here.
              if (instr.dest == DEST_FILE) begin
                file_wr_en   = 1'b1;
                file_wr_data = dec_result;
              end else begin
                st_d.core.acc = dec_result;
              end
              if (dec_result == DATA_ZERO) begin
                st_d.phase             = ST_FLUSH;
                st_d.skip_pending      = 1'b1;
                st_d.core.no_operation = 1'b1;
              end
            end
            INCREMENT_SKIP_ON_NULL: begin
              if (instr.dest == DEST_FILE) begin
                file_wr_en   = 1'b1;
                file_wr_data = inc_result;
              end else begin
                st_d.core.acc = inc_result;
              end
              if (inc_result == DATA_ZERO) begin
                st_d.phase             = ST_FLUSH;
                st_d.skip_pending      = 1'b1;
                st_d.core.no_operation = 1'b1;
              end
            end
            INCREMENT_FILE: begin
              if (instr.dest == DEST_FILE) begin
                file_wr_en   = 1'b1;
                file_wr_data = inc_result;
              end else begin
                st_d.core.acc = inc_result;
              end
              st_d.core.zero_flag = (inc_result == DATA_ZERO);
            end
            OR_LITERAL_INTO_ACC: begin
              st_d.core.acc       = or_lit_result;
              st_d.core.zero_flag = (or_lit_result == DATA_ZERO);
            end
            OR_ACC_WITH_FILE: begin
              if (instr.dest == DEST_FILE) begin
                file_wr_en   = 1'b1;
                file_wr_data = or_file_result;
              end else begin
                st_d.core.acc = or_file_result;
              end
              st_d.core.zero_flag = (or_file_result == DATA_ZERO);
            end
            ABSOLUTE_BRANCH: begin
              // The fetched successor is stale, so it is flushed: two cycles total.
              st_d.core.program_counter = branch_target;
              st_d.phase                = ST_FLUSH;
              st_d.core.no_operation    = 1'b1;
            end
            default: begin
              // Codes outside the subset are ignored and retire as nothing.
              st_d.core.program_counter = st_q.core.program_counter;
              st_d.core.retired         = 1'b0;
            end
          endcase
        end
      end
      ST_FLUSH: begin
        // A skip steps over the discarded word; a branch already points right.
        st_d.phase = ST_EXECUTE;
        if (st_q.skip_pending) begin
          st_d.core.program_counter = st_q.core.program_counter + PC_STEP;
        end
      end
      default: begin
        st_d.phase = ST_EXECUTE;
      end
    endcase
  end

  // ****************************************************************
  // Registers.
  // ****************************************************************

  // All state moves together; a single update point keeps the skip step from racing it.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{phase: ST_EXECUTE, skip_pending: 1'b0,
                core: '{acc: ACC_RESET, zero_flag: 1'b0, program_counter: PC_RESET,
                        no_operation: 1'b0, retired: 1'b0}};
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign acc                = st_q.core.acc;
  assign zero_flag          = st_q.core.zero_flag;
  assign program_counter    = st_q.core.program_counter;
  assign no_operation_cycle = st_q.core.no_operation;
  assign retired            = st_q.core.retired;

endmodule : cpu_instr_subset_exec

// ===== core/exec_pkg.sv
// Package with the constants, opcodes and carriers of the instruction subset executor.
// What this block does
// - The decrement-and-skip opcode writes the addressed file register minus one to the accumulator when d is 0 or back to the file when d is 1, leaving the zero flag alone.
// - A zero result of decrement-and-skip discards the next instruction and runs a no-operation cycle instead, so it takes two cycles.
// - The increment-and-skip opcode writes the addressed file register plus one to the accumulator when d is 0 or back to the file when d is 1, leaving the zero flag alone.
// - A zero result of increment-and-skip replaces the next instruction with a no-operation cycle, so it takes two cycles.
// - The absolute branch loads its 11-bit operand into program counter bits 10 down to 0.
// - The absolute branch fills program counter bits 14 to 11 from bits 6 to 3 of the upper address latch.
// - The absolute branch takes two instruction cycles and changes no flag.
// - The OR-literal opcode ORs the accumulator with an 8-bit literal into the accumulator and updates the zero flag.
// - The plain increment writes the file register plus one to the accumulator or the file as d selects and updates the zero flag.
// - The OR-with-file opcode ORs the accumulator with the file register into the accumulator or the file as d selects and updates the zero flag.
package exec_pkg;

  // ****************************************************************
  // Widths and reset values.
  // ****************************************************************
  localparam int          DATA_W       = 8;
  localparam int          FILE_ADDR_W  = 7;
  localparam int          PC_W         = 15;
  localparam int          BRANCH_W     = 11;
  localparam int          LATCH_W      = 8;
  localparam int          LATCH_LO     = 3;
  localparam int          LATCH_HI     = 6;
  localparam logic [14:0] PC_RESET     = 15'h0000;
  localparam logic [7:0]  ACC_RESET    = 8'h00;
  localparam logic [7:0]  FILE_RESET   = 8'h00;
  localparam logic [7:0]  DATA_ONE     = 8'h01;
  localparam logic [7:0]  DATA_ZERO    = 8'h00;
  localparam logic [14:0] PC_STEP      = 15'h0001;

  // ****************************************************************
  // Opcodes and destination select.
  // ****************************************************************
  typedef enum logic [2:0] {
    DECREMENT_SKIP_ON_NULL = 3'h0,
    INCREMENT_SKIP_ON_NULL = 3'h1,
    INCREMENT_FILE         = 3'h2,
    OR_LITERAL_INTO_ACC    = 3'h3,
    OR_ACC_WITH_FILE       = 3'h4,
    ABSOLUTE_BRANCH        = 3'h5
  } opcode_type;

  localparam logic DEST_ACC  = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // One-hot execution phases.
  typedef enum logic [1:0] {
    ST_EXECUTE = 2'b01,
    ST_FLUSH   = 2'b10
  } phase_type;

  // ****************************************************************
  // Carriers.
  // ****************************************************************
  typedef struct packed {
    logic                     valid;
    opcode_type               op;
    logic [FILE_ADDR_W-1:0]   file_addr;
    logic                     dest;
    logic [BRANCH_W-1:0]      literal;
  } instr_type;

  typedef struct packed {
    logic [DATA_W-1:0]        acc;
    logic                     zero_flag;
    logic [PC_W-1:0]          program_counter;
    logic                     no_operation;
    logic                     retired;
  } core_state_type;

endpackage : exec_pkg

// ===== core/file_store.sv
// Data file storage: flip-flop registers with one read, one write and one peek port.
`timescale 1ns/1ns
module file_store
  import exec_pkg::*;
#(
  parameter int ADDR_W = FILE_ADDR_W,
  parameter int WORD_W = DATA_W
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [WORD_W-1:0] rd_data,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [WORD_W-1:0] wr_data,
  input  wire logic [ADDR_W-1:0] peek_addr,
  output logic      [WORD_W-1:0] peek_data
);

  localparam int DEPTH = 1 << ADDR_W;

  typedef struct packed {
    logic [DEPTH-1:0][WORD_W-1:0] cells;
  } store_type;

  store_type st_q;
  store_type st_d;

  // Reads are combinational so an instruction sees its operand in its own cycle.
  assign rd_data   = st_q.cells[rd_addr];
  assign peek_data = st_q.cells[peek_addr];

  // Next-state: one cell written per cycle at most.
  always_comb begin
    st_d = st_q;
    if (wr_en) begin
      st_d.cells[wr_addr] = wr_data;
    end
  end

  // All cells clear at reset so a fresh core reads known values.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{cells: {DEPTH{FILE_RESET[WORD_W-1:0]}}};
    end else begin
      st_q <= st_d;
    end
  end

endmodule : file_store

// ===== testbench/cpu_exec_props.sv
// Concurrent checks of the instruction subset executor, bound to its top ports.
`timescale 1ns/1ns
module cpu_exec_props
  import exec_pkg::*;
(
  input wire logic               clk_sys,
  input wire logic               rst_n,
  input wire instr_type          instr,
  input wire logic               instr_ready,
  input wire logic [LATCH_W-1:0] upper_address_latch,
  input wire logic [DATA_W-1:0]  acc,
  input wire logic               zero_flag,
  input wire logic [PC_W-1:0]    program_counter,
  input wire logic               no_operation_cycle
);
  // ****************************************************************
  // Request qualifiers and sequences.
  // ****************************************************************
  // A request only counts on an edge where the block says it is ready.
  logic take;
  logic skip_op;
  assign take    = instr.valid && instr_ready;
  assign skip_op = instr.op == DECREMENT_SKIP_ON_NULL || instr.op == INCREMENT_SKIP_ON_NULL;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_branch;
    take && instr.op == ABSOLUTE_BRANCH;
  endsequence
  sequence s_skip;
    take && skip_op;
  endsequence
  // The flush is exactly one refused cycle, then the block is ready again.
  sequence s_flush;
    no_operation_cycle && !instr_ready ##1 !no_operation_cycle && instr_ready;
  endsequence

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  AST_BR_TARGET: assert property (s_branch |=> program_counter ==
    {$past(upper_address_latch[6:3]), $past(instr.literal)}) else $error("branch target wrong");
  AST_BR_FLUSH: assert property (s_branch |=> s_flush) else $error("branch flush wrong");
  AST_BR_FLAGS: assert property (s_branch |=> $stable(zero_flag) && $stable(acc))
    else $error("branch touched state");
  AST_BR_HOLD: assert property (s_branch ##1 1 |=> $stable(program_counter))
    else $error("pc moved in branch flush");
  AST_SKIP_FLAG: assert property (s_skip |=> $stable(zero_flag))
    else $error("skip changed zero flag");
  AST_SKIP_TAKEN: assert property (s_skip and instr.dest == DEST_ACC |=>
    no_operation_cycle == (acc == DATA_ZERO)) else $error("skip decision wrong");
  AST_SKIP_END: assert property (s_skip ##1 no_operation_cycle |=>
    program_counter == $past(program_counter) + PC_STEP && instr_ready)
    else $error("skipped word not stepped over");
  AST_STEP_PC: assert property (take && instr.op <= OR_ACC_WITH_FILE |=>
    program_counter == $past(program_counter) + PC_STEP) else $error("pc step wrong");
  AST_OR_LIT: assert property (take && instr.op == OR_LITERAL_INTO_ACC |=>
    acc == ($past(acc) | $past(instr.literal[7:0])) && zero_flag == (acc == DATA_ZERO))
    else $error("or literal wrong");
  AST_ZF_ACC: assert property (take && instr.dest == DEST_ACC &&
    (instr.op == INCREMENT_FILE || instr.op == OR_ACC_WITH_FILE) |=>
    zero_flag == (acc == DATA_ZERO)) else $error("zero flag wrong");
endmodule : cpu_exec_props

bind cpu_instr_subset_exec cpu_exec_props cpu_exec_props_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .instr(instr), .instr_ready(instr_ready),
  .upper_address_latch(upper_address_latch), .acc(acc), .zero_flag(zero_flag),
  .program_counter(program_counter), .no_operation_cycle(no_operation_cycle)
);

// ===== testbench/cpu_instr_subset_exec_tb_top.sv
// Self-checking bench of the instruction subset executor with a reference model.
`timescale 1ns/1ns
module cpu_instr_subset_exec_tb_top;
  import exec_pkg::*;
  logic           clk_sys, rst_n, instr_ready, zero_flag, no_operation_cycle, retired;
  instr_type      instr;
  logic [7:0]     latch, acc, peek_data, m_acc;
  logic [6:0]     peek_addr;
  logic [14:0]    program_counter, m_pc;
  logic           m_zf;
  logic [7:0]     mem [128];
  logic [31:0]    seed = 32'h5427FE07;
  int             n_mismatch = 0, total_checks = 0, cycles = 0;
  core_state_type exp_q [$];

  cpu_instr_subset_exec cpu_instr_subset_exec_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .instr(instr), .instr_ready(instr_ready), .upper_address_latch(latch), .acc(acc),
    .zero_flag(zero_flag), .program_counter(program_counter),
    .no_operation_cycle(no_operation_cycle), .retired(retired), .peek_addr(peek_addr),
    .peek_data(peek_data));

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check_state(input core_state_type e, input core_state_type s);
    total_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value state expected %h seen %h", e, s);
    end
  endtask : check_state

  task automatic check_word(input string what, input logic [7:0] e, input logic [7:0] s);
    total_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, e, s);
    end
  endtask : check_word

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  // Drives one request at a falling edge, holds it until taken and notes the result.
  task automatic issue(input logic [2:0] o, input logic [6:0] f, input logic d,
                       input logic [10:0] k);
    logic [7:0] r;
    logic       skip;
    seed  = lfsr(seed);
    instr = '{valid: 1'b1, op: opcode_type'(o), file_addr: f, dest: d, literal: k};
    latch = seed[7:0];
    while (instr_ready !== 1'b1) @(negedge clk_sys);
    skip = 1'b0;
    r    = (o == 3'h0) ? mem[f] - DATA_ONE : mem[f] + DATA_ONE;
    if (o == 3'h3) r = m_acc | k[7:0];
    if (o == 3'h4) r = m_acc | mem[f];
    if (o <= 3'h4) begin
      skip = o < 3'h2 && r == DATA_ZERO;
      if (o >= 3'h2) m_zf = r == DATA_ZERO;
      if (d == DEST_FILE && o != 3'h3) mem[f] = r;
      else m_acc = r;
      m_pc = m_pc + PC_STEP;
    end else if (o == 3'h5) m_pc = {latch[6:3], k};
    // Codes 6 and 7 leave no note, since they must retire nothing.
    if (o <= 3'h5) exp_q.push_back('{m_acc, m_zf, m_pc, skip || o == 3'h5, 1'b1});
    if (skip) m_pc = m_pc + PC_STEP;
    @(negedge clk_sys);
  endtask : issue

  // ****************************************************************
  // Clock, watchdog and result monitor.
  // ****************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // A hang in the handshake would otherwise stall the run forever.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 4000) begin
      n_mismatch++;
      summarize();
    end
  end

  // Each retire pulse consumes the oldest noted result.
  always @(negedge clk_sys) begin
    if (retired === 1'b1 && exp_q.size() == 0) begin
      n_mismatch++;
      $display("wrong value retire expected 0 seen 1");
    end else if (retired === 1'b1) begin
      check_state(exp_q.pop_front(), {acc, zero_flag, program_counter, no_operation_cycle,
        retired});
    end
  end

  // Directed corner cases first, then a random mix over a few file cells.
  initial begin
    rst_n = 1'b0;
    instr = '0;
    latch = 8'h00;
    peek_addr = 7'h00;
    m_acc = ACC_RESET;
    m_zf = 1'b0;
    m_pc = PC_RESET;
    foreach (mem[i]) mem[i] = FILE_RESET;
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    check_state('0, {acc, zero_flag, program_counter, no_operation_cycle, retired});
    issue(3'h3, 7'h00, 1'b0, 11'h000);
    issue(3'h0, 7'h03, 1'b0, 11'h000);
    issue(3'h4, 7'h03, 1'b1, 11'h000);
    issue(3'h1, 7'h03, 1'b1, 11'h000);
    issue(3'h2, 7'h03, 1'b1, 11'h000);
    issue(3'h0, 7'h03, 1'b1, 11'h000);
    issue(3'h5, 7'h00, 1'b0, 11'h7FF);
    issue(3'h5, 7'h00, 1'b0, 11'h2A5);
    repeat (150) begin
      seed = lfsr(seed);
      issue(seed[2:0], {4'h0, seed[5:3]}, seed[6], seed[17:7]);
    end
    instr.valid = 1'b0;
    repeat (3) @(negedge clk_sys);
    check_word("pending", 8'h00, 8'(exp_q.size()));
    // One address per cycle, moved at the falling edge, read well before the next rise.
    for (int a = 0; a < 128; a++) begin
      @(negedge clk_sys);
      peek_addr = 7'(a);
      #1;
      check_word("file", mem[a], peek_data);
    end
    summarize();
  end
endmodule : cpu_instr_subset_exec_tb_top
